// ### design/iocfg_regs.sv
// IO setup register bank with clock output select, pull-down and transmit ramp control
`timescale 1ns/1ps
`include "iocfg_defines.svh"

module iocfg_regs (
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [5:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_set_default,
    input wire logic i_osc_running,
    input wire logic i_clk_3m39,
    input wire logic i_clk_6m78,
    input wire logic i_clk_13m56,
    input wire logic i_clk_32k,
    input wire logic i_ss_n,
    input wire logic i_sdo_driving,
    input wire logic i_tx_on,
    output logic [7:0] O_RDATA,
    output logic O_RD_VALID,
    output logic O_SINGLE_DRIVER,
    output logic O_ALTERNATE_DRIVER_SELECT,
    output logic [6:0] O_RX_WATER_LEVEL,
    output logic [6:0] O_TX_WATER_LEVEL,
    output logic O_XTAL_27M12,
    output logic O_MCU_CLK,
    output logic O_LOW_SUPPLY_MODE,
    output logic O_DIGITAL_SUPPLY_RAIL_OFF,
    output logic O_SDO_PULLDOWN_EN,
    output logic O_SDO_DRIVE_HIGH,
    output logic O_TX_SLOW_RAMP,
    output logic O_TX_RAMP_BUSY
);
    localparam logic [7:0] RAMP_CYCLES = 8'(`IOCFG_RAMP_CYCLES);

    logic [7:0] setup_one_q;
    logic [7:0] setup_two_q;
    logic [7:0] ramp_cnt_q;
    logic tx_on_q;
    iocfg_pkg::iocfg_txst_t tx_st_q;
    iocfg_pkg::iocfg_clksel_t clk_sel;
    logic mcu_clk_d;

    function automatic logic [6:0] lvl_pick(input logic sel, input logic [6:0] lo,
                                            input logic [6:0] hi);
        lvl_pick = sel ? hi : lo;
    endfunction

    // Power-up reset only; set-default request is deliberately ignored
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            setup_one_q <= `IOCFG_ONE_RESET;
            setup_two_q <= `IOCFG_TWO_RESET;
        end else if (i_wr_en) begin
            if (i_addr == `IOCFG_ADDR_SETUP_ONE) begin
                setup_one_q <= i_wdata;
            end
            if (i_addr == `IOCFG_ADDR_SETUP_TWO) begin
                setup_two_q <= i_wdata & `IOCFG_TWO_WMASK;
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_RDATA <= 8'h00;
            O_RD_VALID <= 1'b0;
        end else begin
            O_RD_VALID <= i_rd_en;
            if (!i_rd_en) begin
                O_RDATA <= 8'h00;
            end else if (i_addr == `IOCFG_ADDR_SETUP_ONE) begin
                O_RDATA <= setup_one_q;
            end else if (i_addr == `IOCFG_ADDR_SETUP_TWO) begin
                O_RDATA <= setup_two_q;
            end else begin
                O_RDATA <= 8'h00;
            end
        end
    end

    // Static control outputs
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_SINGLE_DRIVER <= 1'b0;
            O_ALTERNATE_DRIVER_SELECT <= 1'b0;
            O_RX_WATER_LEVEL <= `IOCFG_RX_LVL_LOW;
            O_TX_WATER_LEVEL <= `IOCFG_TX_LVL_LOW;
            O_XTAL_27M12 <= 1'b1;
            O_LOW_SUPPLY_MODE <= 1'b0;
            O_DIGITAL_SUPPLY_RAIL_OFF <= 1'b0;
            O_SDO_DRIVE_HIGH <= 1'b0;
            O_TX_SLOW_RAMP <= 1'b0;
        end else begin
            O_SINGLE_DRIVER <= setup_one_q[`IOCFG_ONE_SINGLE];
            O_ALTERNATE_DRIVER_SELECT <= setup_one_q[`IOCFG_ONE_SINGLE]
                & setup_one_q[`IOCFG_ONE_ALT_DRV];
            O_RX_WATER_LEVEL <= lvl_pick(setup_one_q[`IOCFG_ONE_RX_LVL],
                `IOCFG_RX_LVL_LOW, `IOCFG_RX_LVL_HIGH);
            O_TX_WATER_LEVEL <= lvl_pick(setup_one_q[`IOCFG_ONE_TX_LVL],
                `IOCFG_TX_LVL_LOW, `IOCFG_TX_LVL_HIGH);
            O_XTAL_27M12 <= setup_one_q[`IOCFG_ONE_XTAL];
            O_LOW_SUPPLY_MODE <= setup_two_q[`IOCFG_TWO_LOW_SUP];
            O_DIGITAL_SUPPLY_RAIL_OFF <= setup_two_q[`IOCFG_TWO_REG_OFF];
            O_SDO_DRIVE_HIGH <= setup_two_q[`IOCFG_TWO_DRIVE];
            O_TX_SLOW_RAMP <= setup_two_q[`IOCFG_TWO_SLOW];
        end
    end

    // Pull-down on the serial data output
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_SDO_PULLDOWN_EN <= 1'b0;
        end else begin
            O_SDO_PULLDOWN_EN <= (setup_two_q[`IOCFG_TWO_PD_SEL] & !i_ss_n & !i_sdo_driving)
                | (setup_two_q[`IOCFG_TWO_PD_IDLE] & i_ss_n);
        end
    end

    // Clock output mux
    assign clk_sel = iocfg_pkg::iocfg_clksel_t'({setup_one_q[`IOCFG_ONE_CLK_HI],
                                                 setup_one_q[`IOCFG_ONE_CLK_LO]});

    always_comb begin
        mcu_clk_d = 1'b0;
        case (clk_sel)
            iocfg_pkg::IOCFG_CLK_OFF: begin
                mcu_clk_d = 1'b0;
            end
            default: begin
                if (!i_osc_running) begin
                    mcu_clk_d = i_clk_32k & !setup_one_q[`IOCFG_ONE_LF_OFF];
                end else if (clk_sel == iocfg_pkg::IOCFG_CLK_3M39) begin
                    mcu_clk_d = i_clk_3m39;
                end else if (clk_sel == iocfg_pkg::IOCFG_CLK_6M78) begin
                    mcu_clk_d = i_clk_6m78;
                end else begin
                    mcu_clk_d = i_clk_13m56;
                end
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_MCU_CLK <= 1'b0;
        end else begin
            O_MCU_CLK <= mcu_clk_d;
        end
    end

    // Slow transmit ramp timer
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            tx_on_q <= 1'b0;
            tx_st_q <= iocfg_pkg::IOCFG_TX_IDLE;
            ramp_cnt_q <= 8'h00;
            O_TX_RAMP_BUSY <= 1'b0;
        end else begin
            tx_on_q <= i_tx_on;
            case (tx_st_q)
                iocfg_pkg::IOCFG_TX_IDLE: begin
                    if (i_tx_on && !tx_on_q && setup_two_q[`IOCFG_TWO_SLOW]) begin
                        tx_st_q <= iocfg_pkg::IOCFG_TX_RAMP;
                        ramp_cnt_q <= RAMP_CYCLES - 8'h01;
                        O_TX_RAMP_BUSY <= 1'b1;
                    end else if (i_tx_on) begin
                        tx_st_q <= iocfg_pkg::IOCFG_TX_ON;
                    end
                end
                iocfg_pkg::IOCFG_TX_RAMP: begin
                    if (!i_tx_on) begin
                        tx_st_q <= iocfg_pkg::IOCFG_TX_IDLE;
                        O_TX_RAMP_BUSY <= 1'b0;
                    end else if (ramp_cnt_q == 8'h00) begin
                        tx_st_q <= iocfg_pkg::IOCFG_TX_ON;
                        O_TX_RAMP_BUSY <= 1'b0;
                    end else begin
                        ramp_cnt_q <= ramp_cnt_q - 8'h01;
                    end
                end
                iocfg_pkg::IOCFG_TX_ON: begin
                    if (!i_tx_on) begin
                        tx_st_q <= iocfg_pkg::IOCFG_TX_IDLE;
                    end
                end
                default: begin
                    tx_st_q <= iocfg_pkg::IOCFG_TX_IDLE;
                    O_TX_RAMP_BUSY <= 1'b0;
                end
            endcase
        end
    end

    logic unused_ok;
    assign unused_ok = i_set_default;
endmodule

// ### design/iocfg_defines.svh
// Offsets, field positions, reset values and timing counts of the IO setup registers
`ifndef IOCFG_DEFINES_SVH
`define IOCFG_DEFINES_SVH

`define IOCFG_ADDR_SETUP_ONE 6'h00
`define IOCFG_ADDR_SETUP_TWO 6'h01

`define IOCFG_ONE_SINGLE 7
`define IOCFG_ONE_ALT_DRV 6
`define IOCFG_ONE_RX_LVL 5
`define IOCFG_ONE_TX_LVL 4
`define IOCFG_ONE_XTAL 3
`define IOCFG_ONE_CLK_HI 2
`define IOCFG_ONE_CLK_LO 1
`define IOCFG_ONE_LF_OFF 0

`define IOCFG_TWO_LOW_SUP 7
`define IOCFG_TWO_REG_OFF 6
`define IOCFG_TWO_PD_SEL 4
`define IOCFG_TWO_PD_IDLE 3
`define IOCFG_TWO_DRIVE 2
`define IOCFG_TWO_SLOW 0

`define IOCFG_ONE_RESET 8'h08
`define IOCFG_TWO_RESET 8'h00
`define IOCFG_TWO_WMASK 8'hDD

`define IOCFG_RX_LVL_LOW 7'h40
`define IOCFG_RX_LVL_HIGH 7'h50
`define IOCFG_TX_LVL_LOW 7'h20
`define IOCFG_TX_LVL_HIGH 7'h10

`define IOCFG_CLK_MHZ 25
`define IOCFG_RAMP_US 10
`define IOCFG_RAMP_CYCLES (`IOCFG_RAMP_US * `IOCFG_CLK_MHZ)

`endif

// ### design/iocfg_pkg.sv
// Types of the IO setup register bank
package iocfg_pkg;
    typedef enum logic [1:0] {
        IOCFG_CLK_3M39,
        IOCFG_CLK_6M78,
        IOCFG_CLK_13M56,
        IOCFG_CLK_OFF
    } iocfg_clksel_t;

    typedef enum logic [1:0] {
        IOCFG_TX_IDLE,
        IOCFG_TX_RAMP,
        IOCFG_TX_ON
    } iocfg_txst_t;
endpackage

// ### verif/iocfg_properties.sv
// Port checks for the IO setup register bank
`timescale 1ns/1ps
module iocfg_properties (
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [5:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_tx_on,
    input wire logic O_RD_VALID,
    input wire logic O_SINGLE_DRIVER,
    input wire logic O_ALTERNATE_DRIVER_SELECT,
    input wire logic [6:0] O_RX_WATER_LEVEL,
    input wire logic [6:0] O_TX_WATER_LEVEL,
    input wire logic O_XTAL_27M12,
    input wire logic O_MCU_CLK,
    input wire logic O_TX_SLOW_RAMP,
    input wire logic O_TX_RAMP_BUSY
);
    wire w0 = i_wr_en && i_addr == 6'h00;
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESETN);
    property p_single; w0 |-> ##2 O_SINGLE_DRIVER == $past(i_wdata[7], 2); endproperty
    a_single: assert property (p_single) else $error("single mode wrong");
    property p_alt;
        w0 |-> ##2 O_ALTERNATE_DRIVER_SELECT == ($past(i_wdata[7], 2) && $past(i_wdata[6], 2));
    endproperty
    a_alt: assert property (p_alt) else $error("driver select wrong");
    property p_rx; w0 |-> ##2 O_RX_WATER_LEVEL == ($past(i_wdata[5], 2) ? 7'h50 : 7'h40); endproperty
    a_rx: assert property (p_rx) else $error("rx level wrong");
    property p_tx; w0 |-> ##2 O_TX_WATER_LEVEL == ($past(i_wdata[4], 2) ? 7'h10 : 7'h20); endproperty
    a_tx: assert property (p_tx) else $error("tx level wrong");
    property p_xtal; w0 |-> ##2 O_XTAL_27M12 == $past(i_wdata[3], 2); endproperty
    a_xtal: assert property (p_xtal) else $error("crystal select wrong");
    property p_off; w0 && i_wdata[2:1] == 2'b11 ##1 !w0 |-> ##1 !O_MCU_CLK; endproperty
    a_off: assert property (p_off) else $error("clock output not held low");
    property p_rdv; i_rd_en |=> O_RD_VALID; endproperty
    a_rdv: assert property (p_rdv) else $error("read answer missing");
    property p_ramp; $rose(O_TX_RAMP_BUSY) |-> O_TX_SLOW_RAMP && $past(i_tx_on); endproperty
    a_ramp: assert property (p_ramp) else $error("ramp without cause");
endmodule
bind iocfg_regs iocfg_properties u_iocfg_properties (.*);

// ### verif/iocfg_clk_src.sv
// Oscillator side model feeding the clock output selector
`timescale 1ns/1ps
module iocfg_clk_src (
    input wire logic i_clk,
    input wire logic i_run,
    output logic o_c3,
    output logic o_c6,
    output logic o_c13,
    output logic o_c32k
);
    logic [7:0] cnt_q = 8'h00;
    always @(posedge i_clk) begin
        cnt_q <= cnt_q + 8'h01;
    end
    // Crystal taps stand still while stopped
    assign o_c3 = i_run & cnt_q[2];
    assign o_c6 = i_run & cnt_q[1];
    assign o_c13 = i_run & cnt_q[0];
    assign o_c32k = cnt_q[4];
endmodule

// ### verif/iocfg_regs_tb.sv
// Testbench of the IO setup register bank
`timescale 1ns/1ps
module iocfg_regs_tb;
    logic I_REF_CLK = 0, I_RESETN = 0, i_wr_en = 0, i_rd_en = 0, i_set_default = 0;
    logic i_osc_running = 1, i_ss_n = 1, i_sdo_driving = 0, i_tx_on = 0, lf_off = 0, mclk_exp;
    logic [5:0] i_addr = 6'h00;
    logic [7:0] i_wdata = 8'h00, O_RDATA;
    logic [1:0] sel = 2'h0;
    logic [6:0] O_RX_WATER_LEVEL, O_TX_WATER_LEVEL;
    logic O_RD_VALID, O_SINGLE_DRIVER, O_ALTERNATE_DRIVER_SELECT, O_XTAL_27M12, O_MCU_CLK;
    logic O_LOW_SUPPLY_MODE, O_DIGITAL_SUPPLY_RAIL_OFF, O_SDO_PULLDOWN_EN, O_SDO_DRIVE_HIGH;
    logic O_TX_SLOW_RAMP, O_TX_RAMP_BUSY, i_clk_3m39, i_clk_6m78, i_clk_13m56, i_clk_32k;
    int num_errors = 0, num_checks = 0, cyc = 0;
    iocfg_regs u_iocfg_regs (.*);
    iocfg_clk_src u_iocfg_clk_src (.i_clk(I_REF_CLK), .i_run(i_osc_running), .o_c3(i_clk_3m39),
        .o_c6(i_clk_6m78), .o_c13(i_clk_13m56), .o_c32k(i_clk_32k));
    always #20 I_REF_CLK = ~I_REF_CLK;
    always @(posedge I_REF_CLK) begin
        mclk_exp <= sel == 2'h3 ? 1'b0 : !i_osc_running ? !lf_off & i_clk_32k :
            sel == 2'h0 ? i_clk_3m39 : sel == 2'h1 ? i_clk_6m78 : i_clk_13m56;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        i_wr_en = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(negedge I_REF_CLK);
        i_wr_en = 1'b0;
        repeat (2) @(negedge I_REF_CLK);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        i_rd_en = 1'b1;
        i_addr = a;
        @(negedge I_REF_CLK);
        chk("valid", O_RD_VALID, 8'h01);
        chk("rdata", O_RDATA, e);
        i_rd_en = 1'b0;
        @(negedge I_REF_CLK);
    endtask
    task automatic ramp(input logic [7:0] e);
        int n;
        n = 0;
        i_tx_on = 1'b1;
        repeat (300) begin
            @(negedge I_REF_CLK);
            if (O_TX_RAMP_BUSY === 1'b1) n++;
        end
        i_tx_on = 1'b0;
        @(negedge I_REF_CLK);
        chk("ramp", n[7:0], e);
    endtask
    initial begin
        repeat (20) @(negedge I_REF_CLK);
        I_RESETN = 1'b1;
        rd(6'h00, 8'h08);
        rd(6'h01, 8'h00);
        chk("rx", O_RX_WATER_LEVEL, 8'h40);
        chk("tx", O_TX_WATER_LEVEL, 8'h20);
        wr(6'h00, 8'hF0);
        chk("single", O_SINGLE_DRIVER, 8'h01);
        chk("alt", O_ALTERNATE_DRIVER_SELECT, 8'h01);
        chk("rx", O_RX_WATER_LEVEL, 8'h50);
        chk("tx", O_TX_WATER_LEVEL, 8'h10);
        chk("xtal", O_XTAL_27M12, 8'h00);
        wr(6'h01, 8'hFF);
        chk("two", {O_LOW_SUPPLY_MODE, O_DIGITAL_SUPPLY_RAIL_OFF, O_SDO_DRIVE_HIGH,
            O_TX_SLOW_RAMP}, 8'h0F);
        i_set_default = 1'b1;
        @(negedge I_REF_CLK);
        i_set_default = 1'b0;
        rd(6'h01, 8'hDD);
        rd(6'h00, 8'hF0);
        rd(6'h2A, 8'h00);
        for (int t = 0; t < 2; t++) begin
            wr(6'h01, t ? 8'h08 : 8'h10);
            for (int k = 0; k < 4; k++) begin
                i_ss_n = k[1];
                i_sdo_driving = k[0];
                @(negedge I_REF_CLK);
                chk("pd", O_SDO_PULLDOWN_EN, t ? k[1] : k == 0);
            end
        end
        for (int m = 0; m < 16; m++) begin
            i_osc_running = m[3];
            sel = m[2:1];
            lf_off = m[0];
            wr(6'h00, {5'h01, m[2:0]});
            repeat (12) begin
                @(negedge I_REF_CLK);
                chk("mclk", O_MCU_CLK, mclk_exp);
            end
        end
        wr(6'h01, 8'h01);
        ramp(8'hFA);
        wr(6'h01, 8'h00);
        ramp(8'h00);
        conclude();
    end
endmodule
